// [rtl/ptd_port.sv]
// port t data register with per-pin output source priority
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ptd_params.svh"
// Functional notes
// - free pins act as plain i/o steered by data and direction bits
// - general output drives the stored data bit onto the pin
// - read gives stored bit when direction is 1, else synced pin level
// - bits 7-6 and 3-1: enabled timer output overrides plain i/o
// - bit 5 chooses timer, routed pwm, clock output or plain i/o
// - bit 5: enabled timer output beats pwm, clock output and i/o
// - bit 5: without timer, enabled pwm beats clock output and i/o
// - bit 5: enabled clock output beats plain i/o when nothing higher is active
// - bits 4 and 0: enabled timer output beats pwm and plain i/o
// - bits 4 and 0: without timer, enabled pwm overrides plain i/o
module ptd_port
    import ptd_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    // direction and alternative sources from other units
    input wire logic [7:0] DIR,
    input wire logic [7:0] TIMER_MODULE_OUTPUT_EN,
    input wire logic [7:0] TIMER_MODULE_OUTPUT,
    input wire logic [7:0] PWM_ROUTE_EN,
    input wire logic [7:0] PWM_ROUTE_OUT,
    input wire logic PERIODIC_INTERRUPT_CLOCK_OUT_EN,
    input wire logic PERIODIC_INTERRUPT_CLOCK_OUT,
    // pads
    input wire logic [7:0] PAD_IN,
    output logic [7:0] PAD_OUT,
    output logic [7:0] PAD_OE
);

    ptd_state_t s_q;
    ptd_state_t s_d;
    ptd_alt_t alt;
    ptd_wb_req_t req;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // pick one pin source in priority order; returns {oe, level}
    function automatic logic [1:0] pick_src(
        input logic t_en, input logic t_val,
        input logic p_en, input logic p_val,
        input logic c_en, input logic c_val,
        input logic dir, input logic dat);
        logic [1:0] r;
        if (t_en)
            r = {1'b1, t_val};
        else if (p_en)
            r = {1'b1, p_val};
        else if (c_en)
            r = {1'b1, c_val};
        else
            r = {dir, dat};
        return r;
    endfunction

    // merge write data into a byte under lane 0 select
    function automatic logic [7:0] wr_byte(
        input logic [7:0] old, input logic [31:0] wd, input logic s0);
        return s0 ? wd[7:0] : old;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // gather the loose inputs into carriers
    always_comb
    begin
        alt.tmr_en = TIMER_MODULE_OUTPUT_EN;
        alt.tmr_out = TIMER_MODULE_OUTPUT;
        alt.pwm_en = PWM_ROUTE_EN & `PTD_PWM_MASK;
        alt.pwm_out = PWM_ROUTE_OUT;
        alt.clk_en = PERIODIC_INTERRUPT_CLOCK_OUT_EN;
        alt.clk_out = PERIODIC_INTERRUPT_CLOCK_OUT;
        req.cyc = WB_CYC_I;
        req.stb = WB_STB_I;
        req.we = WB_WE_I;
        req.adr = WB_ADR_I;
        req.sel = WB_SEL_I;
        req.dat = WB_DAT_I;
    end

    // one process computes every next value
    always_comb
    begin
        logic [1:0] sel_r;
        logic [7:0] rd_view;
        logic hit;
        sel_r = 2'h0;
        rd_view = 8'h00;
        hit = 1'b0;
        s_d = s_q;
        // pads pass two flops before any logic reads them
        s_d.pin_meta_q = PAD_IN;
        s_d.pin_sync_q = s_q.pin_meta_q;
        // per-pin source priority; only bits 0,4,5 see routed pwm
        for (int i = 0; i < 8; i++)
        begin
            sel_r = pick_src(alt.tmr_en[i], alt.tmr_out[i],
                alt.pwm_en[i], alt.pwm_out[i],
                (i == `PTD_CLK_BIT) && alt.clk_en, alt.clk_out,
                DIR[i], s_q.data_q[i]);
            s_d.pad_oe_q[i] = sel_r[1];
            s_d.pad_out_q[i] = sel_r[0];
        end
        // read view mixes stored bits and pin levels per direction
        rd_view = (s_q.data_q & DIR) | (s_q.pin_sync_q & ~DIR);
        // ack lasts one cycle, then drops even if the master lingers
        s_d.ack_q = 1'b0;
        s_d.err_q = 1'b0;
        if (req.cyc && req.stb && !s_q.ack_q && !s_q.err_q)
        begin
            hit = 1'b1;
            s_d.rdat_q = 32'h0;
            case (req.adr)
                `PTD_DATA_OFFSET:
                begin
                    s_d.rdat_q = {24'h0, rd_view};
                    if (req.we)
                        s_d.data_q = wr_byte(s_q.data_q, req.dat,
                            req.sel[0]);
                end
                `PTD_DIR_OFFSET: s_d.rdat_q = {24'h0, DIR};
                `PTD_INPUT_OFFSET: s_d.rdat_q = {24'h0, s_q.pin_sync_q};
                default: hit = 1'b0;
            endcase
            s_d.ack_q = hit;
            s_d.err_q = !hit;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_q <= '0;
            s_q.data_q <= `PTD_DATA_RESET;
        end
        else
            s_q <= s_d;
    end

    // outputs straight from flops
    assign PAD_OUT = s_q.pad_out_q;
    assign PAD_OE = s_q.pad_oe_q;
    assign WB_ACK_O = s_q.ack_q;
    assign WB_ERR_O = s_q.err_q;
    assign WB_DAT_O = s_q.rdat_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    a_timer_wins_pin: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[1] |=> PAD_OE[1] &&
            PAD_OUT[1] == $past(TIMER_MODULE_OUTPUT[1]))
        else $error("timer output lost pin 1");

    a_bit5_timer_first: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[5] && PWM_ROUTE_EN[5] |=>
            PAD_OUT[5] == $past(TIMER_MODULE_OUTPUT[5]))
        else $error("bit 5 timer did not win");

    a_bit5_pwm_second: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[5] && PWM_ROUTE_EN[5] |=>
            PAD_OE[5] && PAD_OUT[5] == $past(PWM_ROUTE_OUT[5]))
        else $error("bit 5 pwm did not win");

    a_clock_out_third: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[5] && !PWM_ROUTE_EN[5] &&
            PERIODIC_INTERRUPT_CLOCK_OUT_EN |=> PAD_OE[5] &&
            PAD_OUT[5] == $past(PERIODIC_INTERRUPT_CLOCK_OUT))
        else $error("clock output did not win");

    a_bit0_pwm_route: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[0] && PWM_ROUTE_EN[0] |=>
            PAD_OE[0] && PAD_OUT[0] == $past(PWM_ROUTE_OUT[0]))
        else $error("bit 0 pwm not routed");

    a_bit4_timer_first: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[4] |=>
            PAD_OUT[4] == $past(TIMER_MODULE_OUTPUT[4]))
        else $error("bit 4 timer did not win");

    a_gpio_drive_data: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[7:6] == 2'h0 && DIR[7] |=>
            PAD_OE[7] && PAD_OUT[7] == $past(s_q.data_q[7]))
        else $error("output mode does not drive data");

    a_input_no_drive: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[2] && !DIR[2] |=> !PAD_OE[2])
        else $error("input pin driven");

    a_read_mixes_dir: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && !WB_ERR_O &&
            WB_ADR_I == `PTD_DATA_OFFSET && DIR == 8'hff |=>
            WB_ACK_O && WB_DAT_O[7:0] == $past(s_q.data_q))
        else $error("read of output bits not stored value");

    a_ack_one_cycle: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");

    // bit 0 timer beats the routed pwm as well
    a_bit0_timer_first: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[0] |=> PAD_OE[0] &&
            PAD_OUT[0] == $past(TIMER_MODULE_OUTPUT[0]))
        else $error("bit 0 timer did not win");

    // plain timer-only pins: bit 2
    a_bit2_timer_wins: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[2] |=> PAD_OE[2] &&
            PAD_OUT[2] == $past(TIMER_MODULE_OUTPUT[2]))
        else $error("timer output lost pin 2");

    // bit 4 takes routed pwm once its timer is off
    a_bit4_pwm_route: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[4] && PWM_ROUTE_EN[4] |=>
            PAD_OE[4] && PAD_OUT[4] == $past(PWM_ROUTE_OUT[4]))
        else $error("bit 4 pwm not routed");

    // pwm enable on a timer-only pin must be ignored by the mask
    a_bit1_no_pwm: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[1] && PWM_ROUTE_EN[1] && DIR[1] |=>
            PAD_OE[1] && PAD_OUT[1] == $past(s_q.data_q[1]))
        else $error("pwm leaked onto bit 1");

    // bit 5 timer also beats the clock output
    a_bit5_timer_clock: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        TIMER_MODULE_OUTPUT_EN[5] && PERIODIC_INTERRUPT_CLOCK_OUT_EN |=>
            PAD_OE[5] && PAD_OUT[5] == $past(TIMER_MODULE_OUTPUT[5]))
        else $error("bit 5 timer lost to clock");

    // bit 5 pwm beats the clock output
    a_bit5_pwm_clock: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[5] && PWM_ROUTE_EN[5] &&
            PERIODIC_INTERRUPT_CLOCK_OUT_EN |=>
            PAD_OUT[5] == $past(PWM_ROUTE_OUT[5]))
        else $error("bit 5 pwm lost to clock");

    // bit 5 falls back to plain output when all three are off
    a_bit5_gpio_last: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[5] && !PWM_ROUTE_EN[5] &&
            !PERIODIC_INTERRUPT_CLOCK_OUT_EN && DIR[5] |=>
            PAD_OE[5] && PAD_OUT[5] == $past(s_q.data_q[5]))
        else $error("bit 5 plain output lost");

    // bit 0 plain output when no source claims it
    a_bit0_gpio_last: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[0] && !PWM_ROUTE_EN[0] && DIR[0] |=>
            PAD_OE[0] && PAD_OUT[0] == $past(s_q.data_q[0]))
        else $error("bit 0 plain output lost");

    // an idle input pin must never be driven
    a_bit4_input_off: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[4] && !PWM_ROUTE_EN[4] && !DIR[4] |=>
            !PAD_OE[4])
        else $error("input pin 4 driven");

    // bit 5 input needs the clock output off too
    a_bit5_input_off: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !TIMER_MODULE_OUTPUT_EN[5] && !PWM_ROUTE_EN[5] &&
            !PERIODIC_INTERRUPT_CLOCK_OUT_EN && !DIR[5] |=> !PAD_OE[5])
        else $error("input pin 5 driven");

    // input bits read back the synchronised pin level
    a_read_input_bits: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && !WB_ERR_O &&
            WB_ADR_I == `PTD_DATA_OFFSET && DIR == 8'h00 |=>
            WB_ACK_O && WB_DAT_O[7:0] == $past(s_q.pin_sync_q))
        else $error("read of input bits not pin level");

    // unmapped offsets answer with an error pulse only
    a_err_unmapped: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O &&
            WB_ADR_I != `PTD_DATA_OFFSET && WB_ADR_I != `PTD_DIR_OFFSET &&
            WB_ADR_I != `PTD_INPUT_OFFSET |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped access not refused");

    // a write with lane 0 selected lands in the data bits
    a_write_lands: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && !WB_ERR_O &&
            WB_ADR_I == `PTD_DATA_OFFSET && WB_SEL_I[0] |=>
            s_q.data_q == $past(WB_DAT_I[7:0]))
        else $error("data write did not land");

    // without lane 0 the stored bits must not move
    a_write_no_lane: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && !WB_ERR_O &&
            WB_ADR_I == `PTD_DATA_OFFSET && !WB_SEL_I[0] |=>
            $stable(s_q.data_q))
        else $error("unselected lane changed data");

    // no answer without a cycle in progress
    a_idle_no_answer: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !WB_CYC_I |=> !WB_ACK_O && !WB_ERR_O)
        else $error("answer without a cycle");

    // the error pulse is one cycle, like ack
    a_err_one_cycle: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        WB_ERR_O |=> !WB_ERR_O)
        else $error("err held two cycles");

endmodule
`default_nettype wire

// [rtl/ptd_params.svh]
// offsets, reset values and field positions for the port t data block
`ifndef PTD_PARAMS_SVH
`define PTD_PARAMS_SVH
`define PTD_DATA_OFFSET 6'h00
`define PTD_DIR_OFFSET 6'h04
`define PTD_INPUT_OFFSET 6'h08
`define PTD_DATA_RESET 8'h00
`define PTD_DIR_RESET 8'h00
`define PTD_BIT_SHARED 3
`define PTD_PWM_MASK 8'h31
`define PTD_CLK_BIT 5
`endif

// [rtl/ptd_pkg.sv]
// types shared by the port t data block
package ptd_pkg;
    // wishbone request as sampled by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ptd_wb_req_t;

    // alternative source enables coming from other units
    typedef struct packed {
        logic [7:0] tmr_en;
        logic [7:0] tmr_out;
        logic [7:0] pwm_en;
        logic [7:0] pwm_out;
        logic clk_en;
        logic clk_out;
    } ptd_alt_t;

    // complete module state
    typedef struct packed {
        logic [7:0] data_q;
        logic [7:0] pin_meta_q;
        logic [7:0] pin_sync_q;
        logic [7:0] pad_out_q;
        logic [7:0] pad_oe_q;
        logic ack_q;
        logic [31:0] rdat_q;
        logic err_q;
    } ptd_state_t;
endpackage

// [tb/ptd_port_bench.sv]
// self-checking bench for the port t data block
`timescale 1ns/1ns
`default_nettype none
module ptd_port_bench;
    // --------------------------------------------------
    // stimulus and observed signals
    // --------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] sel = 4'h1;
    logic [31:0] rd;
    logic ack, err, rerr;
    logic [31:0] rdat;
    logic [7:0] dir = 8'hff;
    logic [7:0] te = 8'h00, to = 8'h00, pe = 8'h00, po = 8'h00;
    logic ce = 1'b0, co = 1'b0;
    logic [7:0] pin = 8'h00;
    logic [7:0] pout, poe;
    int n_fail = 0, n_tests = 0, cyc_n = 0;

    ptd_port dut_u (.SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .WB_ERR_O(err),
        .DIR(dir), .TIMER_MODULE_OUTPUT_EN(te), .TIMER_MODULE_OUTPUT(to),
        .PWM_ROUTE_EN(pe), .PWM_ROUTE_OUT(po),
        .PERIODIC_INTERRUPT_CLOCK_OUT_EN(ce),
        .PERIODIC_INTERRUPT_CLOCK_OUT(co), .PAD_IN(pin), .PAD_OUT(pout),
        .PAD_OE(poe));

    // 100 MHz clock
    always #5 clk = ~clk;

    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard: the whole run needs well under a hundred cycles
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; called just after a rising edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        // ends on ack or err; the bench watchdog catches a hang
        do
            @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1);
        rdat = rd;
        rerr = err;
        chk("bus answer", 32'h1, {31'h0, ack | err});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // keeps one idle cycle between accesses
        @(posedge clk);
    endtask

    // --------------------------------------------------
    // scenarios
    // --------------------------------------------------
    task automatic t_reg();
        wb(1'b0, 6'h00, 32'h0);
        chk("data reset", 32'h0, rdat);
        wb(1'b1, 6'h00, 32'h000000a5);
        wb(1'b0, 6'h00, 32'h0);
        chk("data read", 32'ha5, rdat);
        chk("pad out", 32'ha5, {24'h0, pout});
        chk("pad oe", 32'hff, {24'h0, poe});
        sel <= 4'h0;
        wb(1'b1, 6'h00, 32'h0000005a);
        sel <= 4'h1;
        wb(1'b0, 6'h00, 32'h0);
        chk("lane off keeps", 32'ha5, rdat);
        wb(1'b1, 6'h04, 32'h00000000);
        wb(1'b0, 6'h04, 32'h0);
        chk("dir mirror", 32'hff, rdat);
        wb(1'b0, 6'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        $display("test reg done");
    endtask

    task automatic t_input();
        dir <= 8'h00;
        pin <= 8'h3c;
        repeat (3) @(posedge clk);
        chk("driver off", 32'h0, {24'h0, poe});
        wb(1'b0, 6'h00, 32'h0);
        chk("pin read", 32'h3c, rdat);
        wb(1'b0, 6'h08, 32'h0);
        chk("input view", 32'h3c, rdat);
        $display("test input done");
    endtask

    task automatic pri(input logic [7:0] a, b, c, d, input logic e, f,
        input logic [7:0] g, eoe, eout);
        te <= a;
        to <= b;
        pe <= c;
        po <= d;
        ce <= e;
        co <= f;
        dir <= g;
        repeat (2) @(posedge clk);
        chk("prio oe", {24'h0, eoe}, {24'h0, poe});
        chk("prio out", {24'h0, eout}, {24'h0, pout & poe});
    endtask

    // data register holds a5 here
    task automatic t_prio();
        pri(8'hff, 8'h55, 8'hff, 8'hff, 1, 1, 8'h00, 8'hff, 8'h55);
        pri(8'h00, 8'h00, 8'hff, 8'h00, 1, 1, 8'hff, 8'hff, 8'h84);
        pri(8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'hff, 8'hff, 8'h85);
        pri(8'h0a, 8'h0a, 8'h00, 8'h00, 0, 0, 8'h00, 8'h0a, 8'h0a);
        pri(8'h00, 8'h00, 8'hff, 8'hff, 0, 0, 8'h00, 8'h31, 8'h31);
        $display("test prio done");
    endtask

    // reset for six cycles, then the scenarios
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reg();
        t_input();
        t_prio();
        test_done();
    end
endmodule
`default_nettype wire
